// file: rtl/odl_pkg.sv
/*
 * shared constants and types for the octal dac serial load link:
 * word layout, channel count, state codes and link timing.
 * assumes a 100 MHz mclk_in on both ends of the link.
 */
package odl_pkg;

   // ------------------------------------------------------------
   // word layout
   // ------------------------------------------------------------
   localparam int WORD_BITS    = 16;
   localparam int CHANNELS     = 8;
   localparam int CODE_BITS    = 12;
   localparam int CTRL_FLAG    = 15;              // 1 = control word
   localparam int ADDR_MSB     = 14;
   localparam int ADDR_LSB     = 12;
   localparam int CODE_MSB     = 11;
   localparam int CTRL_LO_BUF  = 0;               // low group buffer enable
   localparam int CTRL_LO_SUP  = 1;               // low group supply select
   localparam int CTRL_HI_BUF  = 2;
   localparam int CTRL_HI_SUP  = 3;
   localparam logic [4:0] BIT_COUNT_FULL = 5'h10;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam logic [3:0]  CTRL_RESET = 4'h0;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int MCLK_PERIOD_NS = 10;
   localparam int SCLK_HALF_NS   = 40;            // 12.5 MHz, under 30 MHz
   localparam int SYNC_HIGH_NS   = 50;            // least frame select high
   localparam int LOAD_PULSE_NS  = 20;            // least load pulse width
   localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int SYNC_HIGH_CYC  = (SYNC_HIGH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef logic [CHANNELS-1:0][CODE_BITS-1:0] odl_bank_t;

   typedef enum logic [1:0] {
      ODL_REF_UNBUF  = 2'b00,
      ODL_REF_BUF    = 2'b01,
      ODL_REF_SUPPLY = 2'b10
   } odl_ref_mode_e;

   typedef enum logic [1:0] {
      ODL_DEV_IDLE  = 2'b00,
      ODL_DEV_SHIFT = 2'b01,
      ODL_DEV_DONE  = 2'b10
   } odl_dev_state_e;

   typedef enum logic [1:0] {
      ODL_HOST_IDLE  = 2'b00,
      ODL_HOST_SETUP = 2'b01,
      ODL_HOST_SHIFT = 2'b10,
      ODL_HOST_GAP   = 2'b11
   } odl_host_state_e;

endpackage

// file: rtl/odl_link_if.sv
/*
 * the three-wire write link plus the load line between host and dac.
 * assumes the host drives every wire and the dac only listens.
 */
`timescale 1ns/1ps

interface odl_link_if;
   logic sync_n;           // frame select, active low
   logic sclk;             // serial clock made by the host
   logic din;              // serial data
   logic load_outputs_n;   // load dac registers, active low

   modport dev  (input  sync_n, sclk, din, load_outputs_n);
   modport host (output sync_n, sclk, din, load_outputs_n);
endinterface

// file: rtl/odl_dac_dev.sv
/*
 * dac end of the serial load link: samples the link on mclk_in,
 * shifts in 16-bit words, writes input registers or the control
 * setting, and moves input registers into dac registers on load.
 * assumes all link wires are asynchronous to mclk_in and that the
 * serial clock stays well below the mclk_in rate.
 */
`timescale 1ns/1ps

// What this block does
// R01: load low copies input registers to dac
// R02: one load pulse updates all new channels
// R03: load may be held permanently low
// R04: frame select fall enables buffers, shifter
// R05: next 16 falling clocks shift bits
// R06: early frame select rise aborts the write
// R07: 16-bit shifter samples data on falls
// R08: buffers power down after each write
// R09: host keeps serial clock under 30 MHz
// R10: each group reference mode from control bits
// R11: decode and write only after 16th fall
// R12: held load makes dac follow input
module odl_dac_dev (
   input  wire logic                    mclk_in,
   input  wire logic                    reset_n_in,
   odl_link_if.dev                      link,
   output odl_pkg::odl_bank_t           dac_code_out,
   output odl_pkg::odl_ref_mode_e       ref_in_low_group_mode_out,
   output odl_pkg::odl_ref_mode_e       ref_in_high_group_mode_out,
   output logic                         link_buf_on_out,
   output logic                         word_done_out,
   output logic                         frame_abort_out
);
   import odl_pkg::*;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // bit 0 sync_n, 1 sclk, 2 din, 3 load_outputs_n
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;
   logic       prev_sync_n;
   logic       prev_sclk;

   // two flops on every link wire
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         pin_meta    <= 4'hB;
         pin_sync    <= 4'hB;
         prev_sync_n <= 1'b1;
         prev_sclk   <= 1'b1;
      end else begin
         pin_meta    <= {link.load_outputs_n, link.din, link.sclk, link.sync_n};
         pin_sync    <= pin_meta;
         prev_sync_n <= pin_sync[0];
         prev_sclk   <= pin_sync[1];
      end
   end

   logic sync_fall;
   logic sync_rise;
   logic sclk_fall;
   logic load_low;

   // edge finders on the second stage only
   assign sync_fall = prev_sync_n & ~pin_sync[0];
   assign sync_rise = ~prev_sync_n & pin_sync[0];
   assign sclk_fall = prev_sclk & ~pin_sync[1];
   assign load_low  = ~pin_sync[3];

   // ------------------------------------------------------------
   // frame and shift register
   // ------------------------------------------------------------
   odl_dev_state_e state;
   odl_dev_state_e next_state;
   logic [15:0]    shift_reg;
   logic [15:0]    next_shift_reg;
   logic [4:0]     bit_cnt;
   logic [4:0]     next_bit_cnt;
   logic           next_buf_on;
   logic           next_word_done;
   logic           next_abort;

   // frame sequencing
   always_comb begin
      next_state     = state;
      next_shift_reg = shift_reg;
      next_bit_cnt   = bit_cnt;
      next_buf_on    = link_buf_on_out;
      next_word_done = 1'b0;
      next_abort     = 1'b0;
      case (state)
         ODL_DEV_IDLE: begin
            if (sync_fall) begin
               next_state   = ODL_DEV_SHIFT;             // see R04
               next_bit_cnt = 5'h00;
               next_buf_on  = 1'b1;                      // see R04
            end
         end
         ODL_DEV_SHIFT: begin
            if (sync_rise) begin
               next_state   = ODL_DEV_IDLE;              // see R06
               next_buf_on  = 1'b0;
               next_abort   = 1'b1;                      // see R06
            end else if (sclk_fall) begin
               next_shift_reg = {shift_reg[14:0], pin_sync[2]};   // see R07
               next_bit_cnt   = bit_cnt + 5'h01;          // see R05
               if (bit_cnt + 5'h01 == BIT_COUNT_FULL) begin
                  next_state     = ODL_DEV_DONE;
                  next_buf_on    = 1'b0;                  // see R08
                  next_word_done = 1'b1;                  // see R11
               end
            end
         end
         ODL_DEV_DONE: begin
            // further clocks ignored until frame select goes high
            if (pin_sync[0]) begin
               next_state = ODL_DEV_IDLE;
            end
         end
         default: begin
            next_state  = ODL_DEV_IDLE;
            next_buf_on = 1'b0;
         end
      endcase
   end

   // frame registers
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         state           <= ODL_DEV_IDLE;
         shift_reg       <= 16'h0000;
         bit_cnt         <= 5'h00;
         link_buf_on_out <= 1'b0;
         word_done_out   <= 1'b0;
         frame_abort_out <= 1'b0;
      end else begin
         state           <= next_state;
         shift_reg       <= next_shift_reg;
         bit_cnt         <= next_bit_cnt;
         link_buf_on_out <= next_buf_on;
         word_done_out   <= next_word_done;
         frame_abort_out <= next_abort;
      end
   end

   // ------------------------------------------------------------
   // word decode, input registers and dac registers
   // ------------------------------------------------------------
   odl_bank_t   in_regs;
   odl_bank_t   next_in_regs;
   odl_bank_t   next_dac;
   logic [7:0]  pending;
   logic [7:0]  next_pending;
   logic [3:0]  ctrl;
   logic [3:0]  next_ctrl;
   logic [2:0]  word_addr;

   assign word_addr = shift_reg[ADDR_MSB:ADDR_LSB];

   // writes after a whole word, copies on load
   always_comb begin
      next_in_regs = in_regs;
      next_ctrl    = ctrl;
      next_dac     = dac_code_out;
      next_pending = pending;
      for (int i = 0; i < CHANNELS; i++) begin
         // copy uses the value held before this cycle's write
         if (load_low && pending[i]) begin
            next_dac[i]     = in_regs[i];                 // see R01
            next_pending[i] = 1'b0;                       // see R02
         end
      end
      if (word_done_out) begin                            // see R11
         if (shift_reg[CTRL_FLAG]) begin
            next_ctrl = shift_reg[3:0];
         end else begin
            next_in_regs[word_addr] = shift_reg[CODE_MSB:0];
            next_pending[word_addr] = 1'b1;               // see R12
         end
      end
   end

   // data registers; a held load drains pending every cycle
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         in_regs      <= {CHANNELS{CODE_RESET}};
         dac_code_out <= {CHANNELS{CODE_RESET}};
         pending      <= 8'h00;
         ctrl         <= CTRL_RESET;
      end else begin
         in_regs      <= next_in_regs;
         dac_code_out <= next_dac;                        // see R03
         pending      <= next_pending;
         ctrl         <= next_ctrl;
      end
   end

   // ------------------------------------------------------------
   // reference mode per channel group
   // ------------------------------------------------------------
   odl_ref_mode_e next_ref_lo;
   odl_ref_mode_e next_ref_hi;

   // supply select beats buffer enable
   always_comb begin
      if (next_ctrl[CTRL_LO_SUP]) begin
         next_ref_lo = ODL_REF_SUPPLY;                    // see R10
      end else if (next_ctrl[CTRL_LO_BUF]) begin
         next_ref_lo = ODL_REF_BUF;
      end else begin
         next_ref_lo = ODL_REF_UNBUF;
      end
      if (next_ctrl[CTRL_HI_SUP]) begin
         next_ref_hi = ODL_REF_SUPPLY;                    // see R10
      end else if (next_ctrl[CTRL_HI_BUF]) begin
         next_ref_hi = ODL_REF_BUF;
      end else begin
         next_ref_hi = ODL_REF_UNBUF;
      end
   end

   // mode registers follow control in the same edge
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         ref_in_low_group_mode_out  <= ODL_REF_UNBUF;
         ref_in_high_group_mode_out <= ODL_REF_UNBUF;
      end else begin
         ref_in_low_group_mode_out  <= next_ref_lo;
         ref_in_high_group_mode_out <= next_ref_hi;
      end
   end

endmodule // odl_dac_dev

// file: rtl/odl_dac_host.sv
/*
 * host end of the serial load link: sends one 16-bit word per request,
 * msb first, with a serial clock divided from mclk_in, and drives the
 * load line as a timed pulse or held low.
 * assumes the user holds the word stable while req_valid_in is high.
 */
`timescale 1ns/1ps

module odl_dac_host (
   input  wire logic        mclk_in,
   input  wire logic        reset_n_in,
   odl_link_if.host         link,
   input  wire logic        req_valid_in,
   input  wire logic [15:0] req_word_in,
   input  wire logic        load_pulse_in,
   input  wire logic        load_hold_in,
   output logic             ready_out
);
   import odl_pkg::*;

   // ------------------------------------------------------------
   // frame sender
   // ------------------------------------------------------------
   odl_host_state_e state;
   odl_host_state_e next_state;
   logic [15:0]     word;
   logic [15:0]     next_word;
   logic [4:0]      bits_left;
   logic [4:0]      next_bits_left;
   logic [3:0]      tick;
   logic [3:0]      next_tick;
   logic            next_sync_n;
   logic            next_sclk;
   logic            next_din;
   logic            next_ready;
   logic [1:0]      load_cnt;
   logic [1:0]      next_load_cnt;
   logic            next_load_n;

   // divider keeps the clock at 12.5 MHz, inside 30 MHz
   always_comb begin
      next_state     = state;
      next_word      = word;
      next_bits_left = bits_left;
      next_tick      = tick;
      next_sync_n    = link.sync_n;
      next_sclk      = link.sclk;
      next_din       = link.din;
      next_ready     = 1'b0;
      case (state)
         ODL_HOST_IDLE: begin
            next_ready = 1'b1;
            if (req_valid_in && ready_out) begin
               next_state     = ODL_HOST_SETUP;
               next_word      = {req_word_in[14:0], 1'b0};
               next_din       = req_word_in[15];
               next_sync_n    = 1'b0;                     // see R04
               next_bits_left = BIT_COUNT_FULL;
               next_tick      = 4'(SCLK_HALF_CYC - 1);    // see R09
               next_ready     = 1'b0;
            end
         end
         ODL_HOST_SETUP, ODL_HOST_SHIFT: begin
            if (tick != 4'h0) begin
               next_tick = tick - 4'h1;
            end else begin
               next_tick  = 4'(SCLK_HALF_CYC - 1);
               next_state = ODL_HOST_SHIFT;
               if (state == ODL_HOST_SETUP || link.sclk) begin
                  next_sclk      = 1'b0;                  // see R05
                  next_bits_left = bits_left - 5'h01;
               end else if (bits_left == 5'h00) begin
                  next_state  = ODL_HOST_GAP;
                  next_sync_n = 1'b1;
                  next_tick   = 4'(SYNC_HIGH_CYC - 1);
               end else begin
                  next_sclk = 1'b1;
                  next_din  = word[15];
                  next_word = {word[14:0], 1'b0};
               end
            end
         end
         ODL_HOST_GAP: begin
            if (tick != 4'h0) begin
               next_tick = tick - 4'h1;
            end else begin
               next_state = ODL_HOST_IDLE;
               next_ready = 1'b1;
               next_sclk  = 1'b1;                         // idle high, so the next first fall is real
            end
         end
         default: begin
            next_state  = ODL_HOST_IDLE;
            next_sync_n = 1'b1;
         end
      endcase
   end

   // load line: timed pulse between frames, or held low
   always_comb begin
      next_load_cnt = load_cnt;
      if (load_cnt != 2'h0) begin
         next_load_cnt = load_cnt - 2'h1;
      end else if (load_pulse_in && state == ODL_HOST_IDLE) begin
         next_load_cnt = 2'(LOAD_PULSE_CYC);               // see R02
      end
      next_load_n = ~(load_hold_in || next_load_cnt != 2'h0);   // see R03
   end

   // registers; every link wire comes from a flop
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         state               <= ODL_HOST_IDLE;
         word                <= 16'h0000;
         bits_left           <= 5'h00;
         tick                <= 4'h0;
         load_cnt            <= 2'h0;
         link.sync_n         <= 1'b1;
         link.sclk           <= 1'b1;
         link.din            <= 1'b0;
         link.load_outputs_n <= 1'b1;
         ready_out           <= 1'b0;
      end else begin
         state               <= next_state;
         word                <= next_word;
         bits_left           <= next_bits_left;
         tick                <= next_tick;
         load_cnt            <= next_load_cnt;
         link.sync_n         <= next_sync_n;
         link.sclk           <= next_sclk;
         link.din            <= next_din;
         link.load_outputs_n <= next_load_n;
         ready_out           <= next_ready;
      end
   end

endmodule // odl_dac_host

// file: tb/odl_dac_monitor.sv
/*
 * checker for the link between host and dac ends, plus the dac status.
 * assumes one 100 MHz mclk_in and a synchronous active low reset.
 */
`timescale 1ns/1ps

module odl_dac_monitor (
   input wire logic mclk_in,
   input wire logic reset_n_in,
   input wire logic sync_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic link_buf_on_out,
   input wire logic word_done_out,
   input wire logic frame_abort_out
);
   logic       sclk_q;
   logic       next_sclk_q;
   logic [4:0] fall_cnt;
   logic [4:0] next_fall_cnt;

   // ------------------------------------------------------------
   // serial clock falls counted within a frame
   // ------------------------------------------------------------
   always_comb begin
      next_sclk_q = sclk;
      next_fall_cnt = fall_cnt;
      if (sync_n) begin
         next_fall_cnt = 5'h00;
      end else if (sclk_q && !sclk) begin
         next_fall_cnt = fall_cnt + 5'h01;
      end
   end

   // register the count
   always_ff @(posedge mclk_in) begin
      if (!reset_n_in) begin
         sclk_q <= 1'b1;
         fall_cnt <= 5'h00;
      end else begin
         sclk_q <= next_sclk_q;
         fall_cnt <= next_fall_cnt;
      end
   end

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);

   // ------------------------------------------------------------
   // link and status relations
   // ------------------------------------------------------------
   a_buf_on_frame: assert property ($fell(sync_n) |-> ##[1:5] link_buf_on_out)
      else $error("buffers not enabled after frame start");
   a_buf_needs_frame: assert property ($rose(link_buf_on_out) |-> !sync_n)
      else $error("buffers enabled outside a frame");
   a_done_in_time: assert property ((sclk_q && !sclk && !sync_n && fall_cnt == 5'h0F)
      |-> ##[1:5] word_done_out)
      else $error("no word done after sixteenth fall");
   a_sixteen_falls: assert property ($rose(sync_n) |-> fall_cnt == 5'h10)
      else $error("frame closed without sixteen falls");
   a_done_one_cycle: assert property (word_done_out |=> !word_done_out)
      else $error("word done longer than one cycle");
   a_done_drops_buf: assert property (word_done_out |-> !link_buf_on_out)
      else $error("buffers still on after the word");
   a_full_no_abort: assert property (($rose(sync_n) && fall_cnt == 5'h10)
      |-> !frame_abort_out [*8])
      else $error("abort after a full frame");
   a_din_at_fall: assert property ((sclk_q && !sclk) |-> $stable(din))
      else $error("data moved at a sampling fall");

endmodule // odl_dac_monitor

// file: tb/odl_dac_tb.sv
/*
 * testbench: host and dac joined on one link, a second dac fed by a
 * bench-made 125 ns serial clock for abort and slow-link cases.
 * assumes odl_pkg, odl_link_if and both ends are compiled first.
 */
`timescale 1ns/1ps

module odl_dac_tb;
   import odl_pkg::*;

   logic          mclk_in = 1'b0;
   logic          reset_n_in = 1'b0;
   logic          req_valid = 1'b0;
   logic [15:0]   req_word = 16'h0000;
   logic          load_pulse = 1'b0;
   logic          load_hold = 1'b0;
   logic          ready, buf_on, done, abort, done2, abort2;
   odl_bank_t     code, code2;
   odl_ref_mode_e mode_lo, mode_hi;
   int            fail_count = 0;
   int            samples_checked = 0;
   int            cyc = 0;
   int            dn2 = 0;
   int            ab2 = 0;

   odl_link_if lk1 ();
   odl_link_if lk2 ();

   odl_dac_host i_odl_dac_host (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(lk1.host),
      .req_valid_in(req_valid), .req_word_in(req_word), .load_pulse_in(load_pulse),
      .load_hold_in(load_hold), .ready_out(ready));
   odl_dac_dev i_odl_dac_dev (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(lk1.dev),
      .dac_code_out(code), .ref_in_low_group_mode_out(mode_lo),
      .ref_in_high_group_mode_out(mode_hi), .link_buf_on_out(buf_on),
      .word_done_out(done), .frame_abort_out(abort));
   odl_dac_dev i_odl_dac_dev_2 (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(lk2.dev),
      .dac_code_out(code2), .ref_in_low_group_mode_out(), .ref_in_high_group_mode_out(),
      .link_buf_on_out(), .word_done_out(done2), .frame_abort_out(abort2));
   odl_dac_monitor i_odl_dac_monitor (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
      .sync_n(lk1.sync_n), .sclk(lk1.sclk), .din(lk1.din), .link_buf_on_out(buf_on),
      .word_done_out(done), .frame_abort_out(abort));

   // ------------------------------------------------------------
   // clock, pulse counters on the second dac, hang limit
   // ------------------------------------------------------------
   always #5 mclk_in = ~mclk_in;

   always @(posedge mclk_in) begin
      cyc++;
      dn2 += int'(done2 === 1'b1);
      ab2 += int'(abort2 === 1'b1);
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end

   // compare one value
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function odl_ref_mode_e want(input logic [1:0] b);
      return b[1] ? ODL_REF_SUPPLY : (b[0] ? ODL_REF_BUF : ODL_REF_UNBUF);
   endfunction

   // one word through the host, wire bits captured at sclk falls
   task send(input logic [15:0] w);
      logic [15:0] cap;
      int          nf, nd, k;
      logic        sp;
      cap = 16'h0000;
      nf = 0;
      nd = 0;
      k = 0;
      sp = 1'b1;
      req_word <= w;
      req_valid <= 1'b1;
      @(posedge mclk_in);
      while (ready !== 1'b1 && k < 300) begin
         @(posedge mclk_in);
         k++;
      end
      req_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge mclk_in);
         if (!lk1.sync_n && sp && !lk1.sclk) begin
            cap = {cap[14:0], lk1.din};
            nf++;
         end
         sp = lk1.sclk;
         nd += int'(done === 1'b1);
         k++;
      end while ((ready !== 1'b1 || k < 8) && k < 400);
      chk(cap, w);
      chk(16'(nf), 16'h0010);
      chk(16'(nd), 16'h0001);
      chk(16'(buf_on), 16'h0000);
   endtask

   // bench-made frame with nb falls; periods of 12 and 13 cycles average 125 ns
   task send2(input logic [15:0] w, input int nb);
      @(posedge mclk_in);
      lk2.sync_n <= 1'b0;
      lk2.din    <= w[15];
      repeat (6) @(posedge mclk_in);
      for (int i = 0; i < nb; i++) begin
         lk2.sclk <= 1'b0;
         repeat (6) @(posedge mclk_in);
         lk2.sclk <= 1'b1;
         lk2.din  <= (i < 15) ? w[14 - i] : ~lk2.din;
         repeat (6 + i % 2) @(posedge mclk_in);
      end
      lk2.sync_n <= 1'b1;
      lk2.din    <= ~lk2.din;
      repeat (8) @(posedge mclk_in);
   endtask

   task pulse_load;
      int lo;
      lo = 0;
      load_pulse <= 1'b1;
      @(posedge mclk_in);
      load_pulse <= 1'b0;
      repeat (6) begin
         @(posedge mclk_in);
         lo += int'(lk1.load_outputs_n === 1'b0);
      end
      repeat (4) @(posedge mclk_in);
      chk(16'(lo), 16'h0002);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_stage_then_load;
      for (int i = 0; i < CHANNELS; i++) send({1'b0, 3'(i), 12'h249 * 12'(i + 1)});
      for (int i = 0; i < CHANNELS; i++) chk(16'(code[i]), 16'h0000);
      pulse_load();
      for (int i = 0; i < CHANNELS; i++) chk(16'(code[i]), 16'(12'(12'h249 * 12'(i + 1))));
   endtask

   task t_only_new;
      send(16'h3111);
      send(16'h3A5C);
      chk(16'(code[3]), 16'h0924);
      pulse_load();
      chk(16'(code[3]), 16'h0A5C);
      chk(16'(code[4]), 16'h0B6D);
   endtask

   task t_held;
      load_hold <= 1'b1;
      send(16'h5123);
      chk(16'(code[5]), 16'h0123);
      send(16'h07FF);
      chk(16'(code[0]), 16'h07FF);
      load_hold <= 1'b0;
   endtask

   task t_ctrl;
      for (int v = 0; v < 16; v++) begin
         send(16'h8000 | 16'(v));
         chk(16'(mode_lo), 16'(want(2'(v))));
         chk(16'(mode_hi), 16'(want(2'(v >> 2))));
      end
      chk(16'(code[5]), 16'h0123);
   endtask

   task t_abort;
      int d0, a0;
      d0 = dn2;
      a0 = ab2;
      send2(16'h1ABC, 10);
      send2(16'h1ABC, 15);
      chk(16'(ab2 - a0), 16'h0002);
      chk(16'(dn2 - d0), 16'h0000);
      chk(16'(code2[1]), 16'h0000);
      send2(16'h1ABC, 16);
      send2(16'h2123, 18);
      chk(16'(code2[1]), 16'h0ABC);
      chk(16'(code2[2]), 16'h0123);
      chk(16'(dn2 - d0), 16'h0002);
      chk(16'(ab2 - a0), 16'h0002);
   endtask

   // main sequence
   initial begin
      lk2.sync_n <= 1'b1;
      lk2.sclk <= 1'b1;
      lk2.din <= 1'b0;
      lk2.load_outputs_n <= 1'b0;
      repeat (16) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
      chk({13'h0000, buf_on, lk1.sync_n, lk1.sclk}, 16'h0003);
      t_stage_then_load();
      t_only_new();
      t_held();
      t_ctrl();
      t_abort();
      close_out();
   end

endmodule // odl_dac_tb
